// ==== rtl/atf_pkg.sv ====
// Purpose: Shared constants for the address translation frame
// Assumes: APB with 32-bit data, byte addresses on paddr[7:0]
// Notes: Offsets, field positions and area limits live here only
package atf_pkg;
  localparam int unsigned AW = 8;
  // Register byte addresses
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_STAT  = 8'h04;
  localparam logic [7:0] A_MISS  = 8'h08;
  localparam logic [7:0] A_PTB   = 8'h0c;
  localparam logic [7:0] A_TVSID = 8'h10;
  localparam logic [7:0] A_TPI   = 8'h14;
  localparam logic [7:0] A_TDAT  = 8'h18;
  localparam logic [7:0] A_TCMD  = 8'h1c;
  localparam logic [7:0] A_TRC   = 8'h20;
  localparam logic [1:0] A_SEG_HI = 2'h1;
  localparam logic [2:0] A_BLK_HI = 3'h4;
  // Control and status bits
  localparam int unsigned C_ITE = 0;
  localparam int unsigned C_DTE = 1;
  localparam int unsigned C_VBS = 2;
  localparam int unsigned C_SF  = 3;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned S_MISS  = 0;
  localparam int unsigned S_FAULT = 1;
  localparam int unsigned CMD_V   = 31;
  localparam int unsigned RC_CHG_LSB = 16;
  // Address geometry
  localparam int unsigned VSID_W = 24;
  localparam int unsigned VA_W   = 52;
  localparam int unsigned SEG_SH = 28;
  localparam int unsigned PG_SH  = 12;
  localparam int unsigned PI_W   = 16;
  localparam int unsigned RPN_W  = 20;
  localparam int unsigned VPN_W  = 40;
  localparam int unsigned BLK_SH = 17;
  localparam int unsigned BEPI_W = 15;
  localparam int unsigned BL_W   = 11;
  // Descriptor word fields
  localparam int unsigned U_VD = 0;
  localparam int unsigned U_VI = 1;
  localparam int unsigned U_BL_LSB = 2;
  localparam int unsigned D_PP_LSB = 0;
  localparam int unsigned D_WIMG_LSB = 3;
  localparam int unsigned PP_W = 2;
  localparam int unsigned WIMG_W = 4;
  localparam logic [1:0] PP_REAL = 2'h2;
  // Predefined physical areas
  localparam logic [11:0] VB_LO = 12'h000;
  localparam logic [11:0] VB_HI = 12'hfff;
  localparam logic [19:0] OFF_OS_END  = 20'h000ff;
  localparam logic [19:0] OFF_VEC_END = 20'h00fff;
  localparam logic [19:0] OFF_IMP_END = 20'h02fff;
  typedef enum logic [1:0] {
    AREA_NONE = 2'h0,
    AREA_OS   = 2'h1,
    AREA_VEC  = 2'h3,
    AREA_IMPL = 2'h2
  } atf_area_t;
endpackage

// ==== rtl/atf_tlb.sv ====
// Purpose: Fully associative page descriptor buffer with page status
// Assumes: Software fills entries; one lookup per cycle
// Notes: Duplicate tags are software's fault; lowest index wins
`timescale 1ns/1ps
`default_nettype none
module atf_tlb #(
  parameter int unsigned N = 8
) (
  input  wire  logic                     pclk,
  input  wire  logic                     presetn,
  input  wire  logic [atf_pkg::VPN_W-1:0]  lk_vpn,
  output logic                           lk_hit,
  output logic [atf_pkg::RPN_W-1:0]      lk_rpn,
  output logic [atf_pkg::PP_W-1:0]       lk_pp,
  output logic [atf_pkg::WIMG_W-1:0]     lk_wimg,
  input  wire  logic                     touch,
  input  wire  logic                     touch_wr,
  input  wire  logic                     wr_en,
  input  wire  logic [$clog2(N)-1:0]     wr_idx,
  input  wire  logic                     wr_valid,
  input  wire  logic [atf_pkg::VPN_W-1:0]  wr_vpn,
  input  wire  logic [atf_pkg::RPN_W-1:0]  wr_rpn,
  input  wire  logic [atf_pkg::PP_W-1:0]   wr_pp,
  input  wire  logic [atf_pkg::WIMG_W-1:0] wr_wimg,
  input  wire  logic [N-1:0]             rc_clr,
  output logic [N-1:0]                   ref_bits,
  output logic [N-1:0]                   chg_bits
);
  logic                         vld_q [N];
  logic [atf_pkg::VPN_W-1:0]    vpn_q [N];
  logic [atf_pkg::RPN_W-1:0]    rpn_q [N];
  logic [atf_pkg::PP_W-1:0]     pp_q  [N];
  logic [atf_pkg::WIMG_W-1:0]   wimg_q [N];
  logic [N-1:0]                 ref_q;
  logic [N-1:0]                 chg_q;
  logic [N-1:0]                 match;
  logic [$clog2(N)-1:0]         hit_idx;

  genvar g;
  for (g = 0; g < N; g++) begin : g_cmp
    assign match[g] = vld_q[g] & (vpn_q[g] == lk_vpn);
  end

  always_comb begin
    hit_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit_idx = i[$clog2(N)-1:0];
      end
    end
  end

  assign lk_hit   = |match;
  assign lk_rpn   = rpn_q[hit_idx];
  assign lk_pp    = pp_q[hit_idx];
  assign lk_wimg  = wimg_q[hit_idx];
  assign ref_bits = ref_q;
  assign chg_bits = chg_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        vld_q[i]  <= 1'b0;
        vpn_q[i]  <= '0;
        rpn_q[i]  <= '0;
        pp_q[i]   <= '0;
        wimg_q[i] <= '0;
      end
    end else if (wr_en) begin
      vld_q[wr_idx]  <= wr_valid;
      vpn_q[wr_idx]  <= wr_vpn;
      rpn_q[wr_idx]  <= wr_rpn;
      pp_q[wr_idx]   <= wr_pp;
      wimg_q[wr_idx] <= wr_wimg;
    end
  end

  // Set beats clear so a touch never vanishes under software clearing
  wire [N-1:0] set_ref = (touch && lk_hit) ? (N'(1) << hit_idx) : '0;
  wire [N-1:0] set_chg = touch_wr ? set_ref : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= '0;
      chg_q <= '0;
    end else begin
      ref_q <= set_ref | (ref_q & ~rc_clr);
      chg_q <= set_chg | (chg_q & ~rc_clr);
    end
  end

  a_ref_on_touch: assert property (@(posedge pclk) disable iff (!presetn)
    touch && lk_hit |=> ref_q[$past(hit_idx)])
    else $error("page referenced bit not set after hit");
  a_chg_on_store: assert property (@(posedge pclk) disable iff (!presetn)
    touch && touch_wr && lk_hit |=> chg_q[$past(hit_idx)])
    else $error("page changed bit not set after store hit");
endmodule // atf_tlb
`default_nettype wire

// ==== rtl/atf_top.sv ====
// Purpose: Effective to physical address translation frame with APB setup
// Assumes: One translation request per cycle, answer one cycle later
// Notes: Page table search is left to software via the buffer load port
// Function
// - Accept 32-bit effective addresses for fetches and data accesses.
// - Build a 52-bit virtual address from the selected segment descriptor.
// - Physical address no wider than effective; excess high bits may drop.
// - Effective space split into 256 Mbyte segments.
// - Block regions from 128 Kbyte to 256 Mbyte via block descriptors.
// - Memory segments split into 4 Kbyte pages, each translated alone.
// - Physical address, protection and attributes come from the descriptor.
// - Page descriptors from memory tables, cached in an on-chip buffer.
// - Block descriptors held fully on-chip in block translation registers.
// - Unit keeps page status as accesses are translated.
// - With sixty-four-bit mode clear, upper 32 effective bits read as zero.
// - Truncation affects fetch and data, ignoring enables; nothing else.
// - Base offsets 0x0_0000 to 0x0_00FF belong to the operating system.
// - Base offsets 0x0_0100 to 0x0_0FFF hold exception vectors.
// - Base offsets 0x0_1000 to 0x0_2FFF are implementation specific.
// - Base prefix is 0x000 with vector base select clear, else 0xFFF.
// - Pages replace upper 20 bits; blocks replace a smaller leading set.
// - Low 12 address bits pass through untranslated.
// - Present the complete 32-bit physical address to memory.
// - Translation disabled means physical equals effective address.
// - Block match wins; parallel page result discarded.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module atf_top #(
  parameter int unsigned PA_W  = 32,
  parameter int unsigned TLB_N = 8,
  parameter int unsigned BLK_N = 4
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        req_valid,
  input  wire  logic        req_instr,
  input  wire  logic        req_write,
  input  wire  logic [63:0] req_ea,
  output logic              rsp_valid,
  output logic [31:0]       rsp_ea,
  output logic [51:0]       rsp_va,
  output logic [31:0]       rsp_pa,
  output logic              rsp_block,
  output logic              rsp_miss,
  output logic              rsp_fault,
  output logic [1:0]        rsp_pp,
  output logic [3:0]        rsp_wimg,
  output logic [1:0]        rsp_area,
  output logic [31:0]       vector_base
);
  localparam int unsigned TI_W = $clog2(TLB_N);
  localparam int unsigned BI_W = $clog2(BLK_N);
  // Drops physical bits an implementation cannot address
  localparam logic [31:0] PA_MASK = 32'hffff_ffff >> (32 - PA_W);

  logic [atf_pkg::CTRL_W-1:0]  ctrl_q;
  logic                        miss_q;
  logic                        fault_q;
  logic [31:0]                 miss_ea_q;
  logic [31:0]                 ptb_q;
  logic [atf_pkg::VSID_W-1:0]  tvsid_q;
  logic [atf_pkg::PI_W-1:0]    tpi_q;
  logic [31:0]                 tdat_q;
  logic [atf_pkg::VSID_W-1:0]  seg_q [16];
  logic [31:0]                 blku_q [BLK_N];
  logic [31:0]                 blkl_q [BLK_N];
  logic [31:0]                 prdata_q;
  logic                        pslverr_q;

  // APB decode
  wire             setup  = psel & ~penable;
  wire             wr_go  = psel & penable & pwrite;
  wire             seg_a  = paddr[7:6] == atf_pkg::A_SEG_HI;
  wire [3:0]       seg_i  = paddr[5:2];
  wire [BI_W-1:0]  blk_i  = paddr[BI_W+2:3];
  wire             blk_a  = (paddr[7:5] == atf_pkg::A_BLK_HI) && (paddr[4:3] < BLK_N);
  wire             wr_ctl = wr_go && paddr == atf_pkg::A_CTRL;
  wire             wr_sts = wr_go && paddr == atf_pkg::A_STAT;
  wire             wr_ptb = wr_go && paddr == atf_pkg::A_PTB;
  wire             wr_tvs = wr_go && paddr == atf_pkg::A_TVSID;
  wire             wr_tpi = wr_go && paddr == atf_pkg::A_TPI;
  wire             wr_tdt = wr_go && paddr == atf_pkg::A_TDAT;
  wire             wr_cmd = wr_go && paddr == atf_pkg::A_TCMD;
  wire             wr_trc = wr_go && paddr == atf_pkg::A_TRC;
  wire             wr_seg = wr_go && seg_a;
  wire             wr_blk = wr_go && blk_a;

  wire             ite = ctrl_q[atf_pkg::C_ITE];
  wire             dte = ctrl_q[atf_pkg::C_DTE];
  wire             vbs = ctrl_q[atf_pkg::C_VBS];
  wire             sf  = ctrl_q[atf_pkg::C_SF];
  wire [11:0]      base_pfx = vbs ? atf_pkg::VB_HI : atf_pkg::VB_LO;

  // Effective address forming
  wire [63:0]      ea64  = sf ? req_ea : {32'h0, req_ea[31:0]};
  wire             ea_oor = |ea64[63:32];
  wire [31:0]      ea    = ea64[31:0];
  wire             xl_en = req_instr ? ite : dte;
  wire [3:0]       seg_n = ea[31:atf_pkg::SEG_SH];
  wire [51:0]      va    = {seg_q[seg_n], ea[atf_pkg::SEG_SH-1:0]};

  // Block array match, one comparator per entry
  logic [BLK_N-1:0] bm;
  logic [31:0]      bpa   [BLK_N];
  logic [1:0]       bpp   [BLK_N];
  logic [3:0]       bwimg [BLK_N];
  genvar g;
  for (g = 0; g < BLK_N; g++) begin : g_blk
    wire [14:0] bepi = blku_q[g][31:atf_pkg::BLK_SH];
    wire [14:0] msk  = {4'h0, blku_q[g][atf_pkg::U_BL_LSB +: atf_pkg::BL_W]};
    wire        v    = req_instr ? blku_q[g][atf_pkg::U_VI] : blku_q[g][atf_pkg::U_VD];
    wire [14:0] brpn = blkl_q[g][31:atf_pkg::BLK_SH];
    assign bm[g]    = v && (((ea[31:atf_pkg::BLK_SH] ^ bepi) & ~msk) == 15'h0);
    assign bpa[g]   = {(brpn & ~msk) | (ea[31:atf_pkg::BLK_SH] & msk),
                       ea[atf_pkg::BLK_SH-1:0]};
    assign bpp[g]   = blkl_q[g][atf_pkg::D_PP_LSB +: atf_pkg::PP_W];
    assign bwimg[g] = blkl_q[g][atf_pkg::D_WIMG_LSB +: atf_pkg::WIMG_W];
  end

  logic [BI_W-1:0] bsel;
  always_comb begin
    bsel = '0;
    for (int i = BLK_N - 1; i >= 0; i--) begin
      if (bm[i]) begin
        bsel = i[BI_W-1:0];
      end
    end
  end

  // Page buffer lookup
  logic        t_hit;
  logic [19:0] t_rpn;
  logic [1:0]  t_pp;
  logic [3:0]  t_wimg;
  logic [TLB_N-1:0] ref_bits;
  logic [TLB_N-1:0] chg_bits;

  wire         b_any  = |bm;
  wire         pg_use = req_valid && xl_en && !b_any && !ea_oor;
  wire         miss_c = xl_en && !b_any && !t_hit && !ea_oor;
  wire [31:0]  pa_pg  = {t_rpn, ea[atf_pkg::PG_SH-1:0]};
  wire [31:0]  pa_c   = PA_MASK & (!xl_en ? ea :
                                   b_any  ? bpa[bsel] : pa_pg);
  wire [1:0]   pp_c   = !xl_en ? atf_pkg::PP_REAL : b_any ? bpp[bsel] : t_pp;
  wire [3:0]   wimg_c = !xl_en ? 4'h0 : b_any ? bwimg[bsel] : t_wimg;
  wire         in_base = pa_c[31:20] == base_pfx;
  wire [19:0]  off     = pa_c[19:0];
  wire [1:0]   area_c  = !in_base                     ? atf_pkg::AREA_NONE :
                         off <= atf_pkg::OFF_OS_END  ? atf_pkg::AREA_OS   :
                         off <= atf_pkg::OFF_VEC_END ? atf_pkg::AREA_VEC  :
                         off <= atf_pkg::OFF_IMP_END ? atf_pkg::AREA_IMPL :
                                                       atf_pkg::AREA_NONE;

  atf_tlb #(
    .N (TLB_N)
  ) u_tlb (
    .pclk     (pclk),
    .presetn  (presetn),
    .lk_vpn   (va[atf_pkg::VA_W-1:atf_pkg::PG_SH]),
    .lk_hit   (t_hit),
    .lk_rpn   (t_rpn),
    .lk_pp    (t_pp),
    .lk_wimg  (t_wimg),
    .touch    (pg_use),
    .touch_wr (req_write),
    .wr_en    (wr_cmd),
    .wr_idx   (pwdata[TI_W-1:0]),
    .wr_valid (pwdata[atf_pkg::CMD_V]),
    .wr_vpn   ({tvsid_q, tpi_q}),
    .wr_rpn   (tdat_q[31:atf_pkg::PG_SH]),
    .wr_pp    (tdat_q[atf_pkg::D_PP_LSB +: atf_pkg::PP_W]),
    .wr_wimg  (tdat_q[atf_pkg::D_WIMG_LSB +: atf_pkg::WIMG_W]),
    .rc_clr   (wr_trc ? pwdata[TLB_N-1:0] : '0),
    .ref_bits (ref_bits),
    .chg_bits (chg_bits)
  );

  // Read mux, latched in the setup cycle so the access phase is zero wait
  logic [31:0] rd_d;
  logic        err_d;
  always_comb begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    if (seg_a) begin
      rd_d = {8'h0, seg_q[seg_i]};
    end else if (blk_a) begin
      rd_d = paddr[2] ? blkl_q[blk_i] : blku_q[blk_i];
    end else begin
      case (paddr)
        atf_pkg::A_CTRL:  rd_d = {28'h0, ctrl_q};
        atf_pkg::A_STAT:  rd_d = {30'h0, fault_q, miss_q};
        atf_pkg::A_MISS:  rd_d = miss_ea_q;
        atf_pkg::A_PTB:   rd_d = ptb_q;
        atf_pkg::A_TVSID: rd_d = {8'h0, tvsid_q};
        atf_pkg::A_TPI:   rd_d = {16'h0, tpi_q};
        atf_pkg::A_TDAT:  rd_d = tdat_q;
        atf_pkg::A_TCMD:  rd_d = 32'h0;
        atf_pkg::A_TRC: begin
          rd_d[TLB_N-1:0] = ref_bits;
          rd_d[atf_pkg::RC_CHG_LSB +: TLB_N] = chg_bits;
        end
        default:          err_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= pwrite ? 32'h0 : rd_d;
      pslverr_q <= err_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & psel & penable;
  assign pready  = 1'b1;

  // Software-owned setup, expected loaded before translation is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= '0;
      ptb_q   <= 32'h0;
      tvsid_q <= '0;
      tpi_q   <= '0;
      tdat_q  <= 32'h0;
    end else begin
      if (wr_ctl) ctrl_q  <= pwdata[atf_pkg::CTRL_W-1:0];
      if (wr_ptb) ptb_q   <= pwdata;
      if (wr_tvs) tvsid_q <= pwdata[atf_pkg::VSID_W-1:0];
      if (wr_tpi) tpi_q   <= pwdata[atf_pkg::PI_W-1:0];
      if (wr_tdt) tdat_q  <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) seg_q[i] <= '0;
      for (int i = 0; i < BLK_N; i++) begin
        blku_q[i] <= 32'h0;
        blkl_q[i] <= 32'h0;
      end
    end else begin
      if (wr_seg) seg_q[seg_i] <= pwdata[atf_pkg::VSID_W-1:0];
      if (wr_blk && !paddr[2]) blku_q[blk_i] <= pwdata;
      if (wr_blk && paddr[2])  blkl_q[blk_i] <= pwdata;
    end
  end

  // Sticky status: a new event in the clearing cycle survives
  wire miss_set  = req_valid && miss_c;
  wire fault_set = req_valid && ea_oor;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_q    <= 1'b0;
      fault_q   <= 1'b0;
      miss_ea_q <= 32'h0;
    end else begin
      miss_q  <= miss_set  | (miss_q  & ~(wr_sts & pwdata[atf_pkg::S_MISS]));
      fault_q <= fault_set | (fault_q & ~(wr_sts & pwdata[atf_pkg::S_FAULT]));
      if (miss_set) miss_ea_q <= ea;
    end
  end

  // Translation answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid <= 1'b0;
      rsp_ea    <= 32'h0;
      rsp_va    <= '0;
      rsp_pa    <= 32'h0;
      rsp_block <= 1'b0;
      rsp_miss  <= 1'b0;
      rsp_fault <= 1'b0;
      rsp_pp    <= 2'h0;
      rsp_wimg  <= 4'h0;
      rsp_area  <= 2'h0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_ea    <= ea;
        rsp_va    <= va;
        rsp_pa    <= pa_c;
        rsp_block <= xl_en && b_any && !ea_oor;
        rsp_miss  <= miss_c;
        rsp_fault <= ea_oor;
        rsp_pp    <= pp_c;
        rsp_wimg  <= wimg_c;
        rsp_area  <= area_c;
      end
    end
  end

  assign vector_base = {base_pfx, 20'h0};

  a_real_mode_pass: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && !xl_en |=> rsp_pa == (PA_MASK & $past(ea)))
    else $error("real mode address not passed through");
  a_low_bits_pass: assert property (@(posedge pclk) disable iff (!presetn)
    rsp_valid |-> rsp_pa[11:0] == rsp_ea[11:0])
    else $error("page offset bits changed");
  a_trunc_upper: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && !sf |=> !rsp_fault && rsp_ea == $past(req_ea[31:0]))
    else $error("upper half not treated as zero");
  a_va_offset: assert property (@(posedge pclk) disable iff (!presetn)
    rsp_valid |-> rsp_va[27:0] == rsp_ea[27:0])
    else $error("virtual address offset wrong");
  a_block_wins: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && xl_en && b_any && !ea_oor |=> rsp_block && !rsp_miss)
    else $error("block match did not take precedence");
  a_miss_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && miss_c |=> miss_q && miss_ea_q == $past(ea) ##1 miss_q || $past(wr_sts))
    else $error("miss not recorded");
  a_os_area: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && pa_c[31:8] == {base_pfx, 12'h000} |=> rsp_area == atf_pkg::AREA_OS)
    else $error("operating system area not flagged");
  a_vec_area: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && pa_c[31:12] == {base_pfx, 8'h00} && pa_c[11:8] != 4'h0
    |=> rsp_area == atf_pkg::AREA_VEC)
    else $error("vector area not flagged");
  a_impl_area: assert property (@(posedge pclk) disable iff (!presetn)
    req_valid && in_base && (off[19:12] == 8'h01 || off[19:12] == 8'h02)
    |=> rsp_area == atf_pkg::AREA_IMPL)
    else $error("implementation area not flagged");
endmodule // atf_top
`default_nettype wire

// ==== verification/atf_core_model.sv ====
// Purpose: Core side model issuing translation requests
// Assumes: Answer lands one cycle after the request edge
// Notes: Released address shows the inverse, never the last value
`timescale 1ns/1ps
`default_nettype none
module atf_core_model (
  input  wire logic        pclk,
  input  wire logic        rsp_valid,
  output logic             req_valid,
  output logic             req_instr,
  output logic             req_write,
  output logic [63:0]      req_ea
);
  logic got = 1'b0;
  initial begin
    req_valid = 1'b0;
    req_instr = 1'b0;
    req_write = 1'b0;
    req_ea    = 64'h0;
  end
  task automatic issue(input logic i, input logic w, input logic [63:0] ea);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_instr <= i;
    req_write <= w;
    req_ea    <= ea;
    @(posedge pclk);
    req_valid <= 1'b0;
    req_ea    <= ~ea;
    #1 got = rsp_valid;
  endtask
endmodule // atf_core_model
`default_nettype wire

// ==== verification/atf_top_test.sv ====
// Purpose: Self-checking bench for the translation frame
// Assumes: Zero-wait APB slave, answer one cycle after request
// Notes: Expected addresses worked out by hand from the mapping
`timescale 1ns/1ps
`default_nettype none
module atf_top_test;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rsp_ea, rsp_pa, vector_base, rd;
  logic [51:0] rsp_va;
  logic [3:0]  rsp_wimg;
  logic [1:0]  rsp_pp, rsp_area;
  logic        pready, pslverr, req_valid, req_instr, req_write, rsp_valid, rsp_block, rsp_miss, rsp_fault, err;
  logic [63:0] req_ea;
  int          mismatches = 0;
  int          comparisons = 0;
  always #12.5 pclk = ~pclk;
  atf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req_instr(req_instr), .req_write(req_write), .req_ea(req_ea),
    .rsp_valid(rsp_valid), .rsp_ea(rsp_ea), .rsp_va(rsp_va), .rsp_pa(rsp_pa), .rsp_block(rsp_block),
    .rsp_miss(rsp_miss), .rsp_fault(rsp_fault), .rsp_pp(rsp_pp), .rsp_wimg(rsp_wimg),
    .rsp_area(rsp_area), .vector_base(vector_base));
  atf_core_model core (.pclk(pclk), .rsp_valid(rsp_valid), .req_valid(req_valid),
    .req_instr(req_instr), .req_write(req_write), .req_ea(req_ea));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task automatic tr(input logic i, input logic wr, input logic [63:0] ea, input logic [31:0] pa,
                    input logic [1:0] area);
    core.issue(i, wr, ea);
    chk("rsp_valid", 1'b1, core.got);
    chk("rsp_pa", pa, rsp_pa);
    chk("rsp_area", area, rsp_area);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    $display("ERROR watchdog expected done seen timeout");
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1 chk("pready", 1'b1, pready);
    chk("vector_base", 32'h0, vector_base);
    tr(1'b0, 1'b0, 64'hdead_beef_0000_0020, 32'h20, 2'h1);
    chk("rsp_ea", 32'h20, rsp_ea);
    chk("rsp_fault", 1'b0, rsp_fault);
    chk("rsp_pp", 2'h2, rsp_pp);
    tr(1'b1, 1'b0, 64'hffff_ffff_0000_0200, 32'h200, 2'h3);
    tr(1'b0, 1'b1, 64'h1500, 32'h1500, 2'h2);
    tr(1'b0, 1'b0, 64'h3000, 32'h3000, 2'h0);
    w(atf_pkg::A_CTRL, 32'h4);
    chk("vector_base", 32'hfff0_0000, vector_base);
    tr(1'b0, 1'b0, 64'hfff0_0010, 32'hfff0_0010, 2'h1);
    tr(1'b0, 1'b0, 64'h10, 32'h10, 2'h0);
    $display("test real_mode done");
    w(atf_pkg::A_PTB, 32'h0010_0000);
    w(8'h44, 32'h12_3456);
    w(atf_pkg::A_TVSID, 32'h12_3456);
    w(atf_pkg::A_TPI, 32'h2345);
    w(atf_pkg::A_TDAT, 32'habcd_e029);
    w(atf_pkg::A_TCMD, 32'h8000_0002);
    w(atf_pkg::A_CTRL, 32'h2);
    tr(1'b0, 1'b1, 64'h1234_5678, 32'habcd_e678, 2'h0);
    chk("rsp_va", 52'h12_3456_234_5678, rsp_va);
    chk("rsp_miss", 1'b0, rsp_miss);
    chk("rsp_pp", 2'h1, rsp_pp);
    chk("rsp_wimg", 4'h5, rsp_wimg);
    r(atf_pkg::A_TRC, 32'h0004_0004, "ref_chg");
    w(atf_pkg::A_TRC, 32'h4);
    r(atf_pkg::A_TRC, 32'h0, "ref_chg_clr");
    core.issue(1'b0, 1'b0, 64'h1234_6678);
    chk("rsp_miss", 1'b1, rsp_miss);
    r(atf_pkg::A_STAT, 32'h1, "status");
    r(atf_pkg::A_MISS, 32'h1234_6678, "miss_ea");
    $display("test page done");
    w(8'h80, 32'h1234_0001);
    w(8'h84, 32'h5550_0002);
    tr(1'b0, 1'b0, 64'h1234_5678, 32'h5550_5678, 2'h0);
    chk("rsp_block", 1'b1, rsp_block);
    chk("rsp_pp", 2'h2, rsp_pp);
    tr(1'b1, 1'b0, 64'h1234_5678, 32'h1234_5678, 2'h0);
    chk("rsp_block", 1'b0, rsp_block);
    w(8'h80, 32'h1234_0005);
    tr(1'b0, 1'b0, 64'h1236_5678, 32'h5552_5678, 2'h0);
    $display("test block done");
    w(atf_pkg::A_CTRL, 32'h8);
    tr(1'b0, 1'b0, 64'h1_0000_0040, 32'h40, 2'h1);
    chk("rsp_fault", 1'b1, rsp_fault);
    chk("rsp_miss", 1'b0, rsp_miss);
    tr(1'b0, 1'b0, 64'h140, 32'h140, 2'h3);
    chk("rsp_fault", 1'b0, rsp_fault);
    r(atf_pkg::A_STAT, 32'h3, "status_fault");
    w(atf_pkg::A_STAT, 32'h3);
    r(atf_pkg::A_STAT, 32'h0, "status_clr");
    $display("test wide_mode done");
    r(8'hfc, 32'h0, "unmapped_rd");
    chk("pslverr", 1'b1, err);
    $display("test apb done");
    end_of_test();
  end
endmodule // atf_top_test
`default_nettype wire
